// ---- hdlc_fifo_levels_test_status_test.sv ----
// testbench: level fields, status reads and fifo flags of hfts_core
`timescale 1ns/1ps
module hdlc_fifo_levels_test_status_test;
    import hfts_pkg::*;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic [5:0]  st = 6'h00;
    logic [7:0]  rxc = 8'h00;
    logic [7:0]  txc = 8'h00;
    wire logic   cs, wr, rd;
    wire logic [4:0] addr;
    wire logic [7:0] wdata, rdata;
    wire logic [31:0] lvl;
    wire logic [3:0] flg;
    wire logic [1:0] vw;
    int          fails = 0;
    int          total_checks = 0;
    // field byte, then rx full, tx full, rx irq, tx low levels
    logic [39:0] rows [8] = '{40'h07_10_80_40_40, 40'h16_20_70_48_38, 40'h25_30_60_50_30,
        40'h34_40_50_58_28, 40'h43_50_40_60_20, 40'h52_60_30_68_18, 40'h61_70_20_70_10,
        40'h70_80_10_78_08};
    always #25 clk_i = ~clk_i;
    hfts_host hfts_host_inst (.clk_i(clk_i), .rdata_i(rdata), .cs_o(cs), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata));
    hfts_core hfts_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(cs), .wr_i(wr), .rd_i(rd),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .receiver_enable_i(st[5]),
        .transmitter_enable_i(st[4]), .recv_bit_clock_i(st[3]), .xmit_bit_clock_i(st[2]),
        .crc_match_i(st[1]), .addr_match_i(st[0]), .rx_fifo_count_i(rxc), .tx_fifo_count_i(txc),
        .recv_full_status_level_o(lvl[31:24]), .xmit_full_status_level_o(lvl[23:16]),
        .recv_full_irq_threshold_o(lvl[15:8]), .xmit_low_irq_threshold_o(lvl[7:0]),
        .rx_fifo_full_status_o(flg[3]), .tx_fifo_full_status_o(flg[2]),
        .recv_bit_clock_view_o(vw[1]), .xmit_bit_clock_view_o(vw[0]),
        .recv_full_interrupt_o(flg[1]), .xmit_low_interrupt_o(flg[0]));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        hfts_host_inst.access(1'h1, a, d, q);
    endtask
    task automatic rreg(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        hfts_host_inst.access(1'h0, a, 8'h00, q);
        check({24'h0, q}, {24'h0, e});
    endtask
    task automatic reset_check(input int n);
        rst_n_i <= 1'h0;
        repeat (n) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        check(lvl, 32'h10104008);
    endtask
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        end_of_test();
    end
    initial begin
        @(posedge clk_i);
        reset_check(20);
        rreg(HFTS_OFS_LEVEL_SELECT, 8'h00);
        rreg(HFTS_OFS_IRQ_SELECT, 8'h00);
        foreach (rows[i]) begin
            wreg(HFTS_OFS_LEVEL_SELECT, rows[i][39:32]);
            wreg(HFTS_OFS_IRQ_SELECT, rows[i][39:32]);
            rreg(HFTS_OFS_IRQ_SELECT, rows[i][39:32]);
            check(lvl, rows[i][31:0]);
        end
        wreg(HFTS_OFS_LEVEL_SELECT, 8'hFF);
        rreg(HFTS_OFS_LEVEL_SELECT, 8'h77);
        wreg(HFTS_OFS_TEST_STATUS, 8'hFF);
        rreg(HFTS_OFS_TEST_STATUS, 8'h00);
        rreg(5'h1F, HFTS_UNMAPPED_READ);
        st <= 6'h2E;
        rreg(HFTS_OFS_TEST_STATUS, 8'h0A);
        check({30'h0, vw}, 32'h2);
        st <= 6'h1D;
        rreg(HFTS_OFS_TEST_STATUS, 8'h05);
        check({30'h0, vw}, 32'h1);
        wreg(HFTS_OFS_LEVEL_SELECT, 8'h00);
        wreg(HFTS_OFS_IRQ_SELECT, 8'h00);
        rxc <= 8'h40;
        txc <= 8'h08;
        repeat (2) @(posedge clk_i);
        check({28'h0, flg}, 32'hB);
        rxc <= 8'h3F;
        txc <= 8'h09;
        repeat (2) @(posedge clk_i);
        check({28'h0, flg}, 32'h8);
        txc <= 8'h10;
        repeat (2) @(posedge clk_i);
        check({28'h0, flg}, 32'hC);
        wreg(HFTS_OFS_LEVEL_SELECT, 8'h77);
        reset_check(1);
        rreg(HFTS_OFS_LEVEL_SELECT, 8'h00);
        end_of_test();
    end
endmodule

// ---- hfts_core.sv ----
// module: fifo level selection, interrupt thresholds and hdlc test status registers
`timescale 1ns/1ps
module hfts_core
    import hfts_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               cs_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic [HFTS_AW-1:0] addr_i,
    input  wire logic [7:0]         wdata_i,
    output logic      [7:0]         rdata_o,
    input  wire logic               receiver_enable_i,
    input  wire logic               transmitter_enable_i,
    input  wire logic               recv_bit_clock_i,
    input  wire logic               xmit_bit_clock_i,
    input  wire logic               crc_match_i,
    input  wire logic               addr_match_i,
    input  wire logic [7:0]         rx_fifo_count_i,
    input  wire logic [7:0]         tx_fifo_count_i,
    output logic      [7:0]         recv_full_status_level_o,
    output logic      [7:0]         xmit_full_status_level_o,
    output logic      [7:0]         recv_full_irq_threshold_o,
    output logic      [7:0]         xmit_low_irq_threshold_o,
    output logic                    rx_fifo_full_status_o,
    output logic                    tx_fifo_full_status_o,
    output logic                    recv_bit_clock_view_o,
    output logic                    xmit_bit_clock_view_o,
    output logic                    recv_full_interrupt_o,
    output logic                    xmit_low_interrupt_o
);
    hfts_fields_t level_sel_reg;
    hfts_fields_t level_sel_next;
    hfts_fields_t irq_sel_reg;
    hfts_fields_t irq_sel_next;
    logic [7:0]   rdata_next;

    wire logic         wr_hit;
    wire logic         rd_hit;
    wire logic         sel_status;
    wire logic         sel_level;
    wire logic         sel_irq;
    wire hfts_status_t status_now;
    wire logic [7:0]   status_byte;
    wire logic [7:0]   level_byte;
    wire logic [7:0]   irq_byte;
    wire logic [7:0]   rx_full_lvl;
    wire logic [7:0]   tx_full_lvl;
    wire logic [7:0]   rx_irq_lvl;
    wire logic [7:0]   tx_irq_lvl;
    wire logic         rx_full_hit;
    wire logic         tx_full_hit;
    wire logic         rx_irq_hit;
    wire logic         tx_low_hit;

    assign wr_hit     = cs_i & wr_i;
    assign rd_hit     = cs_i & rd_i;
    // page decode happens outside; only the low address bits arrive here
    assign sel_status = (addr_i == HFTS_OFS_TEST_STATUS);
    assign sel_level  = (addr_i == HFTS_OFS_LEVEL_SELECT);
    assign sel_irq    = (addr_i == HFTS_OFS_IRQ_SELECT);

    // bit clocks are gated by their enables only; zero stuffing lies downstream
    assign status_now.recv_bit_clock = receiver_enable_i & recv_bit_clock_i;
    assign status_now.xmit_bit_clock = transmitter_enable_i & xmit_bit_clock_i;
    assign status_now.crc_match      = crc_match_i;
    assign status_now.addr_match     = addr_match_i;

    // reserved nibble forced to zero so it never leaks internal state
    assign status_byte = {4'h0, status_now};
    assign level_byte  = {1'b0, level_sel_reg.hi, 1'b0, level_sel_reg.lo};
    assign irq_byte    = {1'b0, irq_sel_reg.hi, 1'b0, irq_sel_reg.lo};

    // unused bits 7 and 3 are dropped on write
    assign level_sel_next = (wr_hit && sel_level) ?
                            {wdata_i[HFTS_POS_HI_FIELD+:3], wdata_i[HFTS_POS_LO_FIELD+:3]} :
                            level_sel_reg;
    assign irq_sel_next   = (wr_hit && sel_irq) ?
                            {wdata_i[HFTS_POS_HI_FIELD+:3], wdata_i[HFTS_POS_LO_FIELD+:3]} :
                            irq_sel_reg;

    // full status: occupancy has reached the selected level
    assign rx_full_hit = (rx_fifo_count_i >= rx_full_lvl);
    assign tx_full_hit = (tx_fifo_count_i >= tx_full_lvl);

    // transmit-low fires at or below its threshold, receive-full at or above
    assign rx_irq_hit  = (rx_fifo_count_i >= rx_irq_lvl);
    assign tx_low_hit  = (tx_fifo_count_i <= tx_irq_lvl);

    // both strobes at once: the read returns the value before the write
    always_comb begin
        if (!rd_hit) begin
            rdata_next = rdata_o;
        end else if (sel_status) begin
            rdata_next = status_byte;
        end else if (sel_level) begin
            rdata_next = level_byte;
        end else if (sel_irq) begin
            rdata_next = irq_byte;
        end else begin
            rdata_next = HFTS_UNMAPPED_READ;
        end
    end

    // one decoder per field keeps the byte arithmetic out of the register logic
    hfts_level_dec #(
        .BASE (HFTS_FULL_BASE),
        .STEP (HFTS_FULL_STEP)
    ) u_rx_full_dec (
        .code_i  (level_sel_reg.hi),
        .level_o (rx_full_lvl)
    );

    hfts_level_dec #(
        .BASE (HFTS_FULL_BASE),
        .STEP (HFTS_FULL_STEP)
    ) u_tx_full_dec (
        .code_i  (level_sel_reg.lo),
        .level_o (tx_full_lvl)
    );

    hfts_level_dec #(
        .BASE (HFTS_RXIRQ_BASE),
        .STEP (HFTS_IRQ_STEP)
    ) u_rx_irq_dec (
        .code_i  (irq_sel_reg.hi),
        .level_o (rx_irq_lvl)
    );

    hfts_level_dec #(
        .BASE (HFTS_TXIRQ_BASE),
        .STEP (HFTS_IRQ_STEP)
    ) u_tx_irq_dec (
        .code_i  (irq_sel_reg.lo),
        .level_o (tx_irq_lvl)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_sel_reg <= {HFTS_RST_FIELD, HFTS_RST_FIELD};
        end else begin
            level_sel_reg <= level_sel_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_sel_reg <= {HFTS_RST_FIELD, HFTS_RST_FIELD};
        end else begin
            irq_sel_reg <= irq_sel_next;
        end
    end

    // read data holds between reads, so a slow host may sample late
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= HFTS_RST_RDATA;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // levels and flags registered: two cycles behind a write, one cycle behind a count change
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            recv_full_status_level_o  <= HFTS_FULL_BASE;
            xmit_full_status_level_o  <= HFTS_FULL_BASE;
            recv_full_irq_threshold_o <= HFTS_RXIRQ_BASE;
            xmit_low_irq_threshold_o  <= HFTS_TXIRQ_BASE;
        end else begin
            recv_full_status_level_o  <= rx_full_lvl;
            xmit_full_status_level_o  <= tx_full_lvl;
            recv_full_irq_threshold_o <= rx_irq_lvl;
            xmit_low_irq_threshold_o  <= tx_irq_lvl;
        end
    end

    // flags are levels, not sticky: they drop once the count moves back
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_fifo_full_status_o <= 1'b0;
            tx_fifo_full_status_o <= 1'b0;
        end else begin
            rx_fifo_full_status_o <= rx_full_hit;
            tx_fifo_full_status_o <= tx_full_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            recv_bit_clock_view_o <= 1'b0;
            xmit_bit_clock_view_o <= 1'b0;
        end else begin
            recv_bit_clock_view_o <= status_now.recv_bit_clock;
            xmit_bit_clock_view_o <= status_now.xmit_bit_clock;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            recv_full_interrupt_o <= 1'b0;
            xmit_low_interrupt_o  <= 1'b0;
        end else begin
            recv_full_interrupt_o <= rx_irq_hit;
            xmit_low_interrupt_o  <= tx_low_hit;
        end
    end
endmodule

// ---- hfts_core_checker.sv ----
// checker: bus reads, bit clock views and fifo flags of hfts_core
`timescale 1ns/1ps
module hfts_core_checker
    import hfts_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               cs_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic [HFTS_AW-1:0] addr_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               receiver_enable_i,
    input wire logic               transmitter_enable_i,
    input wire logic               recv_bit_clock_i,
    input wire logic               xmit_bit_clock_i,
    input wire logic               crc_match_i,
    input wire logic               addr_match_i,
    input wire logic [7:0]         rx_fifo_count_i,
    input wire logic [7:0]         tx_fifo_count_i,
    input wire logic [7:0]         recv_full_status_level_o,
    input wire logic [7:0]         xmit_full_status_level_o,
    input wire logic [7:0]         recv_full_irq_threshold_o,
    input wire logic [7:0]         xmit_low_irq_threshold_o,
    input wire logic               rx_fifo_full_status_o,
    input wire logic               tx_fifo_full_status_o,
    input wire logic               recv_bit_clock_view_o,
    input wire logic               xmit_bit_clock_view_o,
    input wire logic               recv_full_interrupt_o,
    input wire logic               xmit_low_interrupt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_only = cs_i && rd_i && !wr_i;
    chk_rx_clock_view: assert property ($past(rst_n_i) |->
        recv_bit_clock_view_o == $past(receiver_enable_i & recv_bit_clock_i))
        else $error("rx clock view wrong");
    chk_tx_clock_view: assert property ($past(rst_n_i) |->
        xmit_bit_clock_view_o == $past(transmitter_enable_i & xmit_bit_clock_i))
        else $error("tx clock view wrong");
    chk_status_read: assert property (rd_only && addr_i == HFTS_OFS_TEST_STATUS |=>
        rdata_o == {4'h0, $past(receiver_enable_i & recv_bit_clock_i),
        $past(transmitter_enable_i & xmit_bit_clock_i), $past(crc_match_i), $past(addr_match_i)})
        else $error("status read wrong");
    chk_full_levels: assert property (rd_only && addr_i == HFTS_OFS_LEVEL_SELECT |=>
        {recv_full_status_level_o, xmit_full_status_level_o} ==
        {8'h10 + {1'h0, rdata_o[6:4], 4'h0}, 8'h10 + {1'h0, rdata_o[2:0], 4'h0}})
        else $error("full levels disagree with field");
    chk_irq_levels: assert property (rd_only && addr_i == HFTS_OFS_IRQ_SELECT |=>
        {recv_full_irq_threshold_o, xmit_low_irq_threshold_o} ==
        {8'h40 + {2'h0, rdata_o[6:4], 3'h0}, 8'h08 + {2'h0, rdata_o[2:0], 3'h0}})
        else $error("irq thresholds disagree with field");
    // stable threshold so a level still settling after a write is not judged
    chk_rx_irq_flag: assert property ($past(rst_n_i) && $stable(recv_full_irq_threshold_o) |->
        recv_full_interrupt_o == ($past(rx_fifo_count_i) >= recv_full_irq_threshold_o))
        else $error("rx full interrupt wrong");
    chk_tx_low_flag: assert property ($past(rst_n_i) && $stable(xmit_low_irq_threshold_o) |->
        xmit_low_interrupt_o == ($past(tx_fifo_count_i) <= xmit_low_irq_threshold_o))
        else $error("tx low interrupt wrong");
    chk_rx_full_flag: assert property ($past(rst_n_i) && $stable(recv_full_status_level_o) |->
        rx_fifo_full_status_o == ($past(rx_fifo_count_i) >= recv_full_status_level_o))
        else $error("rx full status wrong");
    chk_tx_full_flag: assert property ($past(rst_n_i) && $stable(xmit_full_status_level_o) |->
        tx_fifo_full_status_o == ($past(tx_fifo_count_i) >= xmit_full_status_level_o))
        else $error("tx full status wrong");
endmodule

bind hfts_core hfts_core_checker hfts_core_checker_inst (.*);

// ---- hfts_host.sv ----
// host model: processor side register reads and writes
`timescale 1ns/1ps
module hfts_host
    import hfts_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic [7:0]         rdata_i,
    output logic                    cs_o,
    output logic                    wr_o,
    output logic                    rd_o,
    output logic      [HFTS_AW-1:0] addr_o,
    output logic      [7:0]         wdata_o
);
    initial {cs_o, wr_o, rd_o, addr_o, wdata_o} = '0;
    // released address and data lines show the inverse so a late sample cannot look valid
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        cs_o <= 1'h1;
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        {cs_o, wr_o, rd_o} <= 3'h0;
        addr_o <= ~a;
        wdata_o <= ~d;
        @(posedge clk_i);
        q = rdata_i;
    endtask
endmodule

// ---- hfts_level_dec.sv ----
// module: turns a three-bit level code into a byte count
`timescale 1ns/1ps
module hfts_level_dec
    import hfts_pkg::*;
#(
    parameter logic [7:0] BASE = 8'h10,
    parameter logic [7:0] STEP = 8'h10
) (
    input  wire logic [2:0] code_i,
    output wire logic [7:0] level_o
);
    wire logic [7:0] scaled;

    // top code of the widest span gives exactly 128, still fits eight bits
    assign scaled  = 8'(STEP * {5'h00, code_i});
    assign level_o = 8'(BASE + scaled);
endmodule

// ---- hfts_pkg.sv ----
// package: register map, field layout and level encodings of the hdlc level/test block
package hfts_pkg;
    localparam int          HFTS_AW               = 5;
    localparam logic [4:0]  HFTS_OFS_TEST_STATUS  = 5'h1C;
    localparam logic [4:0]  HFTS_OFS_LEVEL_SELECT = 5'h1D;
    localparam logic [4:0]  HFTS_OFS_IRQ_SELECT   = 5'h1E;

    localparam int          HFTS_POS_HI_FIELD     = 4;
    localparam int          HFTS_POS_LO_FIELD     = 0;
    localparam int          HFTS_POS_RX_CLK       = 3;
    localparam int          HFTS_POS_TX_CLK       = 2;
    localparam int          HFTS_POS_CRC_OK       = 1;
    localparam int          HFTS_POS_ADDR_OK      = 0;

    localparam logic [2:0]  HFTS_RST_FIELD        = 3'h0;
    localparam logic [7:0]  HFTS_RST_RDATA        = 8'h00;
    localparam logic [7:0]  HFTS_UNMAPPED_READ    = 8'h00;

    localparam logic [7:0]  HFTS_FULL_BASE        = 8'h10;
    localparam logic [7:0]  HFTS_FULL_STEP        = 8'h10;
    localparam logic [7:0]  HFTS_RXIRQ_BASE       = 8'h40;
    localparam logic [7:0]  HFTS_TXIRQ_BASE       = 8'h08;
    localparam logic [7:0]  HFTS_IRQ_STEP         = 8'h08;

    typedef struct packed {
        logic recv_bit_clock;
        logic xmit_bit_clock;
        logic crc_match;
        logic addr_match;
    } hfts_status_t;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } hfts_fields_t;
endpackage
